// [src/sram_fifo_block.sv]
/*
 * one 4,608-bit memory block run as a synchronous fifo with its own
 * control unit, configured over axi4-lite.
 * assumes fabric user logic drives both ports on clk and that deeper or
 * wider fifos are built by joining several blocks through their flags.
 */
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "sram_fifo_regs.svh"

// Overview of operation
// - one 4,608-bit array per block
// - aspects 128x36 up to 4608x1 supported
// - separate independent read and write ports
// - read and write widths set independently
// - fifo runs from built-in control only
// - width and depth are programmable settings
// - empty and full flags driven
// - almost flags use programmable thresholds
// - internal read and write pointer counters
// - guard against misuse (refused writes and reads); no metastability synchronizers
// - blocks cascade for deeper or wider
module sram_fifo_block (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wr_en,
  input wire logic [35:0] wr_data,
  input wire logic rd_en,
  output logic [35:0] rd_data,
  output logic rd_valid,
  output sram_fifo_pkg::fifo_flags_s flags,
  output logic irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // aspect code to port width
  function automatic logic [5:0] width_of(input logic [2:0] code);
    case (code)
      3'h0: width_of = 6'h01;
      3'h1: width_of = 6'h02;
      3'h2: width_of = 6'h04;
      3'h3: width_of = 6'h09;
      3'h4: width_of = 6'h12;
      default: width_of = 6'h24;
    endcase
  endfunction

  // ring arithmetic; pointers stay below the programmed capacity
  function automatic logic [12:0] wrap(input logic [12:0] ptr,
      input logic [5:0] add, input logic [12:0] cap);
    logic [13:0] sum;
    sum = {1'b0, ptr} + {8'h00, add};
    if (sum >= {1'b0, cap}) begin
      sum = sum - {1'b0, cap};
    end
    wrap = sum[12:0];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] upd, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? upd[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic [4607:0] mem, next_mem;
  logic [12:0] wptr, rptr, level, next_wptr, next_rptr, next_level;
  logic [35:0] next_rd_data;
  logic next_rd_valid;
  logic [2:0] wr_code, rd_code, next_wr_code, next_rd_code;
  logic [12:0] cap, ae_level, af_level;
  logic [12:0] next_cap, next_ae_level, next_af_level;
  sram_fifo_pkg::int_bits_s int_status, int_mask;
  sram_fifo_pkg::int_bits_s next_int_status, next_int_mask;
  logic [5:0] ww, rw;
  logic wr_ok, rd_ok, flush, full_q, next_full_q;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata, wval;
  logic do_write;

  assign ww = width_of(wr_code);
  assign rw = width_of(rd_code);

  // ****************************************************************
  // flags
  // ****************************************************************
  // empty when a read word is not present
  assign flags.empty = level < {7'h00, rw};
  // full when another write word will not fit
  assign flags.full = ({1'b0, level} + {8'h00, ww}) > {1'b0, cap};
  assign flags.almost_empty_flag = level <= ae_level;
  assign flags.almost_full_flag = level >= af_level;
  assign irq = |(int_status & int_mask);

  // ****************************************************************
  // fifo data path
  // ****************************************************************
  // refuse writes when full, reads when empty
  assign wr_ok = wr_en && !flags.full && !flush;
  assign rd_ok = rd_en && !flags.empty && !flush;

  always_comb begin
    next_mem = mem;
    next_wptr = wptr;
    next_rptr = rptr;
    next_level = level;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    next_full_q = flags.full;
    // write port acts on its own
    if (wr_ok) begin
      for (int i = 0; i < `PORT_BITS; i++) begin
        if (i < ww) begin
          next_mem[wrap(wptr, 6'(i), cap)] = wr_data[i];
        end
      end
      next_wptr = wrap(wptr, ww, cap);
    end
    // read port acts on its own
    if (rd_ok) begin
      for (int i = 0; i < `PORT_BITS; i++) begin
        // read width independent of write width
        next_rd_data[i] = (i < rw) ? mem[wrap(rptr, 6'(i), cap)] : 1'b0;
      end
      next_rptr = wrap(rptr, rw, cap);
      next_rd_valid = 1'b1;
    end
    next_level = level + (wr_ok ? {7'h00, ww} : 13'h0000)
      - (rd_ok ? {7'h00, rw} : 13'h0000);
    // reconfiguration empties the ring to avoid stale words
    if (flush) begin
      next_wptr = 13'h0000;
      next_rptr = 13'h0000;
      next_level = 13'h0000;
    end
  end

  // storage is one 4,608-bit array, no reset needed
  always_ff @(posedge clk) begin
    mem <= next_mem;
  end

  // control unit needs no fabric logic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wptr <= 13'h0000;
      rptr <= 13'h0000;
      level <= 13'h0000;
      rd_data <= 36'h0_0000_0000;
      rd_valid <= 1'b0;
      full_q <= 1'b0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      level <= next_level;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      full_q <= next_full_q;
    end
  end

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    next_wr_code = wr_code;
    next_rd_code = rd_code;
    next_cap = cap;
    next_ae_level = ae_level;
    next_af_level = af_level;
    next_int_mask = int_mask;
    flush = 1'b0;
    wval = 32'h0000_0000;
    // set wins over a same-cycle clear
    next_int_status = int_status;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      case ({aw_addr[7:2], 2'b00})
        `OFS_CTRL: begin
          wval = merge({25'h000_0000, rd_code, 1'b0, wr_code}, w_data,
            w_strb);
          next_wr_code = (wval[`CTRL_WR_LSB +: 3] > 3'h5) ? 3'h5
            : wval[`CTRL_WR_LSB +: 3];
          next_rd_code = (wval[`CTRL_RD_LSB +: 3] > 3'h5) ? 3'h5
            : wval[`CTRL_RD_LSB +: 3];
          flush = 1'b1;
        end
        `OFS_DEPTH: begin
          wval = merge({19'h0_0000, cap}, w_data, w_strb);
          next_cap = (wval[12:0] > `ARRAY_BITS) ? `ARRAY_BITS
            : (wval[12:0] < `MIN_CAP) ? `MIN_CAP : wval[12:0];
          flush = 1'b1;
        end
        `OFS_AE_LEVEL: begin
          wval = merge({19'h0_0000, ae_level}, w_data, w_strb);
          next_ae_level = wval[12:0];
        end
        `OFS_AF_LEVEL: begin
          wval = merge({19'h0_0000, af_level}, w_data, w_strb);
          next_af_level = wval[12:0];
        end
        `OFS_FILL: begin
          next_bresp = `RESP_OKAY;
        end
        `OFS_INT_STATUS: begin
          wval = w_strb[0] ? w_data : 32'h0000_0000;
          next_int_status = int_status & ~wval[2:0];
        end
        `OFS_INT_MASK: begin
          wval = merge({29'h0000_0000, int_mask}, w_data, w_strb);
          next_int_mask = wval[2:0];
        end
        default: begin
          next_bresp = `RESP_DECERR;
        end
      endcase
    end
    // misuse and full entry are recorded
    next_int_status.write_refused = next_int_status.write_refused
      | (wr_en && flags.full);
    next_int_status.read_refused = next_int_status.read_refused
      | (rd_en && flags.empty);
    next_int_status.became_full = next_int_status.became_full
      | (flags.full && !full_q);
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `OFS_CTRL: next_rdata = {25'h000_0000, rd_code, 1'b0, wr_code};
        `OFS_DEPTH: next_rdata = {19'h0_0000, cap};
        `OFS_AE_LEVEL: next_rdata = {19'h0_0000, ae_level};
        `OFS_AF_LEVEL: next_rdata = {19'h0_0000, af_level};
        `OFS_FILL: next_rdata = {12'h000, flags, 3'h0, level};
        `OFS_INT_STATUS: next_rdata = {29'h0000_0000, int_status};
        `OFS_INT_MASK: next_rdata = {29'h0000_0000, int_mask};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `RESP_DECERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      wr_code <= `RST_WR_CODE;
      rd_code <= `RST_RD_CODE;
      cap <= `RST_DEPTH;
      ae_level <= `RST_AE_LEVEL;
      af_level <= `RST_AF_LEVEL;
      int_status <= 3'h0;
      int_mask <= `RST_INT_MASK;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      wr_code <= next_wr_code;
      rd_code <= next_rd_code;
      cap <= next_cap;
      ae_level <= next_ae_level;
      af_level <= next_af_level;
      int_status <= next_int_status;
      int_mask <= next_int_mask;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  full_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && !rd_en && flags.full && !flush |=> level == $past(level))
    else $error("write accepted while full");
  empty_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && !wr_en && flags.empty && !flush |=> !rd_valid)
    else $error("read accepted while empty");
  read_data_a: assert property (@(posedge clk) disable iff (!rst_b)
    rd_valid |-> $past(rd_en) && !$past(flags.empty))
    else $error("read data without accepted read");
  write_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    wr_ok && !rd_en |=> level == $past(level) + {7'h00, $past(ww)})
    else $error("level not raised by write width");
  level_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
    level <= cap && cap <= `ARRAY_BITS)
    else $error("fill level beyond capacity");
  empty_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    flush |=> flags.empty && !flags.full)
    else $error("not empty after flush");
  almost_full_flag_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    wr_ok && !rd_ok && flags.almost_full_flag |=> flags.almost_full_flag
      || af_level != $past(af_level))
    else $error("almost full lost on a write");
  refuse_irq_a: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && flags.full |=> int_status.write_refused)
    else $error("refused write not recorded");
  bus_resp_a: assert property (@(posedge clk) disable iff (!rst_b)
    do_write |=> s_axi_bvalid ##0 !aw_held)
    else $error("write response missing");

endmodule

// [src/sram_fifo_regs.svh]
/*
 * register offsets, reset values and sizes of the embedded fifo block.
 * assumes inclusion by a package or module that uses the macros.
 */
`ifndef SRAM_FIFO_REGS_SVH
`define SRAM_FIFO_REGS_SVH

// ****************************************************************
// array geometry
// ****************************************************************
`define ARRAY_BITS 13'h1200
`define PORT_BITS 36
`define MIN_CAP 13'h0024

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL 8'h00
`define OFS_DEPTH 8'h04
`define OFS_AE_LEVEL 8'h08
`define OFS_AF_LEVEL 8'h0c
`define OFS_FILL 8'h10
`define OFS_INT_STATUS 8'h14
`define OFS_INT_MASK 8'h18

// ****************************************************************
// fields and reset values
// ****************************************************************
`define CTRL_WR_LSB 0
`define CTRL_RD_LSB 4
`define FILL_FLAGS_LSB 16
`define RST_WR_CODE 3'h2
`define RST_RD_CODE 3'h2
`define RST_DEPTH 13'h1200
`define RST_AE_LEVEL 13'h0040
`define RST_AF_LEVEL 13'h11c0
`define RST_INT_MASK 3'h0
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// [src/sram_fifo_pkg.sv]
/*
 * types shared by the embedded fifo block.
 * assumes sram_fifo_regs.svh is on the include path.
 */
package sram_fifo_pkg;
  // ****************************************************************
  // port aspect codes: x1 x2 x4 x9 x18 x36
  // ****************************************************************
  typedef enum logic [2:0] {
    asp_x1 = 3'h0,
    asp_x2 = 3'h1,
    asp_x4 = 3'h2,
    asp_x9 = 3'h3,
    asp_x18 = 3'h4,
    asp_x36 = 3'h5
  } aspect_e;

  typedef struct packed {
    logic almost_full_flag;
    logic almost_empty_flag;
    logic full;
    logic empty;
  } fifo_flags_s;

  typedef struct packed {
    logic read_refused;
    logic write_refused;
    logic became_full;
  } int_bits_s;
endpackage

// [test/fabric_user.sv]
/*
 * fabric user logic at the far side of the fifo ports.
 * assumes the bench asks for transfers and may order it to skip the flags.
 */
`timescale 1ns/1ps
module fabric_user (
  input wire logic want_wr,
  input wire logic want_rd,
  input wire logic ignore_flags,
  input wire logic [35:0] word_in,
  input wire sram_fifo_pkg::fifo_flags_s flags,
  output logic wr_en,
  output logic [35:0] wr_data,
  output logic rd_en
);
  // ****************************************************************
  // transfer gating
  // ****************************************************************
  // flags checked before each transfer unless ignore_flags is set
  assign wr_en = want_wr && (ignore_flags || !flags.full);
  assign rd_en = want_rd && (ignore_flags || !flags.empty);
  // idle data shows the inverse so a stale word never passes as live
  assign wr_data = want_wr ? word_in : ~word_in;
endmodule

// [test/sram_fifo_block_test.sv]
/*
 * self-checking bench of the embedded fifo block.
 * assumes the design package and register header are on the include path.
 */
`timescale 1ns/1ps
`include "sram_fifo_regs.svh"
module sram_fifo_block_test;
  logic clk, rst_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic wr_en, rd_en, rd_valid, irq, want_wr, want_rd, ignore_flags;
  logic [35:0] wr_data, rd_data, word_in;
  sram_fifo_pkg::fifo_flags_s flags;
  int failures, n_tests;

  sram_fifo_block DUT (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wr_en, .wr_data,
    .rd_en, .rd_data, .rd_valid, .flags, .irq);
  fabric_user user (.want_wr, .want_rd, .ignore_flags, .word_in, .flags,
    .wr_en, .wr_data, .rd_en);

  // ****************************************************************
  // bus and port tasks
  // ****************************************************************
  task chk(input string what, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task axi_write(input logic [7:0] a, input logic [31:0] d,
                 output logic [1:0] r);
    logic aw_left, w_left;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    while (aw_left || w_left) begin
      @(posedge clk);
      if (aw_left && s_axi_awready) begin
        aw_left = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_left && s_axi_wready) begin
        w_left = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d,
                output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_write(a, d, rr);
    chk("bresp", {34'h0_0000_0000, `RESP_OKAY}, {34'h0_0000_0000, rr});
  endtask

  task rd_chk(input string what, input logic [7:0] a, input logic [31:0] e,
              input logic [1:0] er);
    axi_read(a, rv, rr);
    chk(what, {4'h0, e}, {4'h0, rv});
    chk("rresp", {34'h0_0000_0000, er}, {34'h0_0000_0000, rr});
  endtask

  // one cycle of request; returns one cycle after the taking edge
  task fifo_op(input logic w, input logic r, input logic f,
               input logic [35:0] d);
    @(posedge clk);
    want_wr <= w;
    want_rd <= r;
    ignore_flags <= f;
    word_in <= d;
    @(posedge clk);
    want_wr <= 1'b0;
    want_rd <= 1'b0;
    ignore_flags <= 1'b0;
    @(posedge clk);
  endtask

  task flags_chk(input logic [3:0] e);
    chk("flags", {32'h0000_0000, e}, {32'h0000_0000, flags});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task reset_values;
    rd_chk("ctrl", `OFS_CTRL, 32'h0000_0022, `RESP_OKAY);
    rd_chk("depth", `OFS_DEPTH, 32'h0000_1200, `RESP_OKAY);
    rd_chk("ae", `OFS_AE_LEVEL, 32'h0000_0040, `RESP_OKAY);
    rd_chk("af", `OFS_AF_LEVEL, 32'h0000_11c0, `RESP_OKAY);
    rd_chk("fill", `OFS_FILL, 32'h0005_0000, `RESP_OKAY);
    rd_chk("mask", `OFS_INT_MASK, 32'h0000_0000, `RESP_OKAY);
    rd_chk("status", `OFS_INT_STATUS, 32'h0000_0000, `RESP_OKAY);
    rd_chk("unmapped", 8'h20, 32'h0000_0000, `RESP_DECERR);
    axi_write(8'h20, 32'h0000_00ff, rr);
    chk("bresp", {34'h0, `RESP_DECERR}, {34'h0, rr});
    flags_chk(4'b0101);
    chk("irq", 36'h0_0000_0000, {35'h0_0000_0000, irq});
  endtask

  task aspect_codes;
    logic [2:0] c;
    for (int i = 0; i < 7; i++) begin
      c = 3'(i);
      wr_ok(`OFS_CTRL, {25'h0, c, 1'b0, c});
      c = (i > 5) ? 3'h5 : 3'(i);
      rd_chk("aspect", `OFS_CTRL, {25'h0, c, 1'b0, c}, `RESP_OKAY);
    end
    wr_ok(`OFS_DEPTH, 32'h0000_1fff);
    rd_chk("depth hi", `OFS_DEPTH, 32'h0000_1200, `RESP_OKAY);
    wr_ok(`OFS_DEPTH, 32'h0000_0000);
    rd_chk("depth lo", `OFS_DEPTH, 32'h0000_0024, `RESP_OKAY);
  endtask

  // nine-bit write taken back as nine single bits, lowest first
  task width_stream;
    logic [8:0] pat;
    pat = 9'h1a5;
    wr_ok(`OFS_CTRL, 32'h0000_0003);
    wr_ok(`OFS_DEPTH, 32'h0000_1200);
    fifo_op(1'b1, 1'b0, 1'b0, {27'h0, pat});
    rd_chk("fill", `OFS_FILL, 32'h0004_0009, `RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      fifo_op(1'b0, 1'b1, 1'b0, 36'h0_0000_0000);
      chk("rd_valid", 36'h0_0000_0001, {35'h0_0000_0000, rd_valid});
      chk("bit", {35'h0_0000_0000, pat[i]}, rd_data);
    end
    flags_chk(4'b0101);
  endtask

  task full_refusal;
    wr_ok(`OFS_CTRL, 32'h0000_0055);
    wr_ok(`OFS_DEPTH, 32'h0000_0048);
    wr_ok(`OFS_AF_LEVEL, 32'h0000_0048);
    wr_ok(`OFS_INT_MASK, 32'h0000_0006);
    fifo_op(1'b1, 1'b0, 1'b0, 36'h1_2345_6789);
    fifo_op(1'b1, 1'b1, 1'b0, 36'h2_468a_cf13);
    chk("same cycle", 36'h1_2345_6789, rd_data);
    fifo_op(1'b1, 1'b0, 1'b0, 36'h3_0f0f_0f0f);
    flags_chk(4'b1010);
    chk("irq masked", 36'h0_0000_0000, {35'h0_0000_0000, irq});
    fifo_op(1'b1, 1'b0, 1'b1, 36'h4_dead_beef);
    chk("irq", 36'h0_0000_0001, {35'h0_0000_0000, irq});
    rd_chk("status", `OFS_INT_STATUS, 32'h0000_0003, `RESP_OKAY);
    wr_ok(`OFS_INT_STATUS, 32'h0000_0003);
    chk("irq clr", 36'h0_0000_0000, {35'h0_0000_0000, irq});
    fifo_op(1'b0, 1'b1, 1'b0, 36'h0_0000_0000);
    chk("word b", 36'h2_468a_cf13, rd_data);
    fifo_op(1'b0, 1'b1, 1'b0, 36'h0_0000_0000);
    chk("word c", 36'h3_0f0f_0f0f, rd_data);
    flags_chk(4'b0101);
    fifo_op(1'b0, 1'b1, 1'b1, 36'h0_0000_0000);
    chk("no read", 36'h0_0000_0000, {35'h0_0000_0000, rd_valid});
    chk("held", 36'h3_0f0f_0f0f, rd_data);
    chk("irq rd", 36'h0_0000_0001, {35'h0_0000_0000, irq});
    rd_chk("status", `OFS_INT_STATUS, 32'h0000_0004, `RESP_OKAY);
    wr_ok(`OFS_INT_STATUS, 32'h0000_0004);
    chk("irq end", 36'h0_0000_0000, {35'h0_0000_0000, irq});
  endtask

  // ****************************************************************
  // run control
  // ****************************************************************
  task stop_test;
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // whole run is a few hundred cycles; ten thousand means a hang
  initial begin
    #40000;
    failures++;
    stop_test;
  end

  initial begin
    failures = 0;
    n_tests = 0;
    rst_b = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    want_wr = 1'b0;
    want_rd = 1'b0;
    ignore_flags = 1'b0;
    word_in = 36'h0_0000_0000;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    reset_values;
    aspect_codes;
    width_stream;
    full_refusal;
    stop_test;
  end
endmodule
